// ---- pkg/vrc_pkg.sv ----
// Constants for the voltage reference control block
package vrc_pkg;
    // Register addresses on the plain register port
    localparam logic [1:0] ADDR_FIXED_CTRL  = 2'h0;
    localparam logic [1:0] ADDR_LADDER_CTRL = 2'h1;
    localparam logic [1:0] ADDR_LEVEL_SEL   = 2'h2;
    localparam int         ADDR_W           = 2;
    localparam int         DATA_W           = 8;

    // Fixed reference control fields
    localparam int FIX_EN_BIT     = 7;
    localparam int FIX_STABLE_BIT = 6;
    localparam int FIX_GAIN_HI    = 5;
    localparam int FIX_GAIN_LO    = 4;
    localparam logic [1:0] FIX_GAIN_RESET = 2'h1;

    // Ladder control fields
    localparam int LAD_EN_BIT   = 7;
    localparam int LAD_LPS_BIT  = 6;
    localparam int LAD_OE_BIT   = 5;
    localparam int LAD_PSS_HI   = 3;
    localparam int LAD_PSS_LO   = 2;
    localparam int LAD_NSS_BIT  = 0;

    // Level code field
    localparam int LEVEL_W  = 5;
    localparam int LEVEL_HI = 4;

    // Positive source encodings
    localparam logic [1:0] PSS_SUPPLY   = 2'h0;
    localparam logic [1:0] PSS_EXT_POS  = 2'h1;
    localparam logic [1:0] PSS_FIXED    = 2'h2;

    // Settling time of the fixed reference
    localparam int CLK_MHZ        = 50;
    localparam int SETTLE_US      = 25;
    localparam int SETTLE_CYCLES  = SETTLE_US * CLK_MHZ;
    localparam int SETTLE_W       = 16;
endpackage

// ---- verif/test_voltage_reference_control.sv ----
// Self-checking testbench for the voltage reference control block
`timescale 1ns/10ps
`define CHK(act, exp) begin check_count++; if ((act) !== (exp)) begin n_mismatch++; \
    $display("wrong value at %0t: got %h expected %h", $time, act, exp); end end
module test_voltage_reference_control;
    logic       core_clk = 1'b0;
    logic       rst      = 1'b1;
    logic [1:0] addr     = 2'h0;
    logic [7:0] wdata    = 8'h00;
    logic       wr       = 1'b0;
    logic       rd       = 1'b0;
    logic       pin_in   = 1'b0;
    logic [7:0] rdata;
    logic       pin_read, pin_ovr, fix_en, fix_cmp, fix_adc;
    logic [1:0] fix_gain, pos_sel;
    logic       lad_en, lad_clamp, lad_lp, neg_sel, lad_oe;
    logic [4:0] level;
    int         n_mismatch  = 0;
    int         check_count = 0;
    // Short settle count keeps the run brief; expectations wait well beyond it
    localparam int SETTLE = 4;
    vrc_top #(.SETTLE_CYCLES(SETTLE)) u_vrc_top (
        .CORE_CLK(core_clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .PIN_DIGITAL_IN(pin_in), .PIN_DIGITAL_READ(pin_read),
        .PIN_DIGITAL_OVERRIDE(pin_ovr), .FIXED_REF_ENABLE(fix_en), .FIXED_REF_GAIN(fix_gain),
        .FIXED_REF_TO_CMP(fix_cmp), .FIXED_REF_TO_ADC(fix_adc), .LADDER_ENABLE(lad_en),
        .LADDER_CLAMP(lad_clamp), .LADDER_LOW_POWER(lad_lp), .LADDER_POS_SEL(pos_sel),
        .LADDER_NEG_SEL(neg_sel), .LADDER_LEVEL(level), .LADDER_PIN_OE(lad_oe));
    initial begin
        forever #10 core_clk = ~core_clk;
    end
    task automatic results();
        if (n_mismatch == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge core_clk) begin addr <= a; wdata <= d; wr <= 1'b1; end
        @(posedge core_clk) wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [1:0] a, input logic [7:0] exp);
        @(posedge core_clk) begin addr <= a; rd <= 1'b1; end
        @(posedge core_clk) rd <= 1'b0;
        #1 `CHK(rdata, exp)
    endtask
    task automatic settle();
        repeat (2) @(posedge core_clk);
        #1;
    endtask
    task automatic do_reset();
        @(posedge core_clk) rst <= 1'b1;
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
    endtask
    task automatic check_reset_state();
        #1;
        `CHK({fix_en, lad_en, lad_clamp, lad_oe, pin_ovr, level}, 10'h080)
        `CHK(fix_gain, vrc_pkg::FIX_GAIN_RESET)
        rd_reg(vrc_pkg::ADDR_FIXED_CTRL, 8'h10);
        rd_reg(vrc_pkg::ADDR_LADDER_CTRL, 8'h00);
        rd_reg(vrc_pkg::ADDR_LEVEL_SEL, 8'h00);
    endtask
    task automatic test_fixed();
        wr_reg(vrc_pkg::ADDR_FIXED_CTRL, 8'hff);
        rd_reg(vrc_pkg::ADDR_FIXED_CTRL, 8'hb0);
        `CHK({fix_en, fix_cmp, fix_adc, fix_gain}, 5'h1f)
        repeat (SETTLE + 4) @(posedge core_clk);
        rd_reg(vrc_pkg::ADDR_FIXED_CTRL, 8'hf0);
        wr_reg(vrc_pkg::ADDR_FIXED_CTRL, 8'h6f);
        settle();
        `CHK({fix_en, fix_cmp, fix_adc, fix_gain}, 5'h02)
        rd_reg(vrc_pkg::ADDR_FIXED_CTRL, 8'h20);
    endtask
    task automatic test_ladder();
        logic [7:0] d;
        wr_reg(vrc_pkg::ADDR_LADDER_CTRL, 8'hff);
        rd_reg(vrc_pkg::ADDR_LADDER_CTRL, 8'hed);
        `CHK({lad_en, lad_clamp, lad_lp, lad_oe, pos_sel, neg_sel}, 7'h5f)
        for (int i = 0; i < 3; i++) begin
            d = {1'b1, 3'h0, i[1:0], 1'b0, i[0]};
            wr_reg(vrc_pkg::ADDR_LADDER_CTRL, d);
            settle();
            `CHK({lad_en, lad_clamp, pos_sel, neg_sel}, {2'h2, i[1:0], i[0]})
            rd_reg(vrc_pkg::ADDR_LADDER_CTRL, d);
        end
        wr_reg(vrc_pkg::ADDR_LADDER_CTRL, 8'h00);
        settle();
        `CHK({lad_en, lad_clamp}, 2'h1)
    endtask
    task automatic test_level();
        logic [7:0] codes [4] = '{8'hff, 8'h01, 8'h10, 8'h35};
        for (int i = 0; i < 4; i++) begin
            wr_reg(vrc_pkg::ADDR_LEVEL_SEL, codes[i]);
            settle();
            `CHK(level, codes[i][4:0])
            rd_reg(vrc_pkg::ADDR_LEVEL_SEL, {3'h0, codes[i][4:0]});
        end
    endtask
    task automatic test_pin();
        pin_in <= 1'b1;
        wr_reg(vrc_pkg::ADDR_LADDER_CTRL, 8'h20);
        repeat (5) @(posedge core_clk);
        #1 `CHK({pin_read, pin_ovr, lad_oe}, 3'h3)
        wr_reg(vrc_pkg::ADDR_LADDER_CTRL, 8'h00);
        repeat (5) @(posedge core_clk);
        #1 `CHK({pin_read, pin_ovr, lad_oe}, 3'h4)
        pin_in <= 1'b0;
    endtask
    task automatic test_unmapped_hold();
        wr_reg(2'h3, 8'hff);
        rd_reg(2'h3, 8'h00);
        // Back-to-back reads with no gap between strobes
        @(posedge core_clk) begin addr <= vrc_pkg::ADDR_LEVEL_SEL; rd <= 1'b1; end
        @(posedge core_clk) addr <= vrc_pkg::ADDR_FIXED_CTRL;
        #1 `CHK(rdata, 8'h15)
        @(posedge core_clk) rd <= 1'b0;
        #1 `CHK(rdata, 8'h20)
        @(posedge core_clk);
        #1 `CHK(rdata, 8'h00)
    endtask
    initial begin
        repeat (5000) @(posedge core_clk);
        n_mismatch++;
        results();
    end
    initial begin
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        check_reset_state();
        test_fixed();
        test_ladder();
        test_level();
        test_pin();
        test_unmapped_hold();
        wr_reg(vrc_pkg::ADDR_LADDER_CTRL, 8'ha0);
        wr_reg(vrc_pkg::ADDR_FIXED_CTRL, 8'h80);
        do_reset();
        check_reset_state();
        results();
    end
endmodule

// ---- verilog/vrc_settle_timer.sv ----
// Settle timer that raises a stable level a fixed count after enable
`timescale 1ns/10ps
module vrc_settle_timer #(
    parameter int SETTLE_CYCLES = 1250
) (
    input  wire logic clk,      // System clock
    input  wire logic rst,      // Synchronous reset, active high
    input  wire logic enable,   // Reference enabled
    output logic      stable    // Settled indication
);
    logic [vrc_pkg::SETTLE_W-1:0] count;

    always_ff @(posedge clk) begin
        if (rst || !enable) begin
            count  <= '0;
            stable <= 1'b0;
        end else if (!stable) begin
            if (count == vrc_pkg::SETTLE_W'(SETTLE_CYCLES - 1)) begin
                stable <= 1'b1;
            end else begin
                count <= count + 1'b1;
            end
        end
    end
endmodule

// ---- verilog/vrc_top.sv ----
// Register file and analog control outputs for the two voltage references
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps

module vrc_top #(
    parameter int SETTLE_CYCLES = vrc_pkg::SETTLE_CYCLES
) (
    input  wire logic       CORE_CLK,          // System clock, 50 MHz
    input  wire logic       RST,               // Synchronous reset, active high
    input  wire logic [1:0] ADDR,              // Register address
    input  wire logic [7:0] WDATA,             // Write data
    input  wire logic       WR,                // Write strobe
    input  wire logic       RD,                // Read strobe
    output logic      [7:0] RDATA,             // Read data, cycle after RD
    input  wire logic       PIN_DIGITAL_IN,    // Raw digital level of reference pin
    output logic            PIN_DIGITAL_READ,  // Digital pin value seen by the core
    output logic            PIN_DIGITAL_OVERRIDE, // Disables pin digital buffers
    output logic            FIXED_REF_ENABLE,  // Fixed reference analog enable
    output logic      [1:0] FIXED_REF_GAIN,    // Fixed reference gain select
    output logic            FIXED_REF_TO_CMP,  // Fixed reference available to comparators
    output logic            FIXED_REF_TO_ADC,  // Fixed reference available to ADC mux
    output logic            LADDER_ENABLE,     // Divider current enable
    output logic            LADDER_CLAMP,      // Clamp ladder output to ground
    output logic            LADDER_LOW_POWER,  // Low-power state select
    output logic      [1:0] LADDER_POS_SEL,    // Upper source select
    output logic            LADDER_NEG_SEL,    // Lower source select
    output logic      [4:0] LADDER_LEVEL,      // Ladder tap code
    output logic            LADDER_PIN_OE      // Drive reference onto its pin
);
    logic       fix_en;
    logic [1:0] fix_gain;
    logic       lad_en;
    logic       lad_lps;
    logic       lad_oe;
    logic [1:0] lad_pss;
    logic       lad_nss;
    logic [4:0] level;
    logic       stable;
    logic       pin_meta;
    logic       pin_sync;
    logic [7:0] next_rdata;

    // Wake from sleep is not a reset input, so contents hold through it
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            fix_en   <= 1'b0;
            fix_gain <= vrc_pkg::FIX_GAIN_RESET;
        end else if (WR && ADDR == vrc_pkg::ADDR_FIXED_CTRL) begin
            fix_en   <= WDATA[vrc_pkg::FIX_EN_BIT];
            fix_gain <= WDATA[vrc_pkg::FIX_GAIN_HI:vrc_pkg::FIX_GAIN_LO];
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            lad_en  <= 1'b0;
            lad_lps <= 1'b0;
            lad_oe  <= 1'b0;
            lad_pss <= vrc_pkg::PSS_SUPPLY;
            lad_nss <= 1'b0;
        end else if (WR && ADDR == vrc_pkg::ADDR_LADDER_CTRL) begin
            lad_en  <= WDATA[vrc_pkg::LAD_EN_BIT];
            lad_lps <= WDATA[vrc_pkg::LAD_LPS_BIT];
            lad_oe  <= WDATA[vrc_pkg::LAD_OE_BIT];
            lad_pss <= WDATA[vrc_pkg::LAD_PSS_HI:vrc_pkg::LAD_PSS_LO];
            lad_nss <= WDATA[vrc_pkg::LAD_NSS_BIT];
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            level <= '0;
        end else if (WR && ADDR == vrc_pkg::ADDR_LEVEL_SEL) begin
            level <= WDATA[vrc_pkg::LEVEL_HI:0];
        end
    end

    vrc_settle_timer #(
        .SETTLE_CYCLES (SETTLE_CYCLES)
    ) u_settle (
        .clk    (CORE_CLK),
        .rst    (RST),
        .enable (fix_en),
        .stable (stable)
    );

    // Unimplemented bits are constant zero; a read has no side effects
    always_comb begin
        next_rdata = 8'h00;
        case (ADDR)
            vrc_pkg::ADDR_FIXED_CTRL: begin
                next_rdata[vrc_pkg::FIX_EN_BIT]     = fix_en;
                next_rdata[vrc_pkg::FIX_STABLE_BIT] = stable;
                next_rdata[vrc_pkg::FIX_GAIN_HI:vrc_pkg::FIX_GAIN_LO] = fix_gain;
            end
            vrc_pkg::ADDR_LADDER_CTRL: begin
                next_rdata[vrc_pkg::LAD_EN_BIT]  = lad_en;
                next_rdata[vrc_pkg::LAD_LPS_BIT] = lad_lps;
                next_rdata[vrc_pkg::LAD_OE_BIT]  = lad_oe;
                next_rdata[vrc_pkg::LAD_PSS_HI:vrc_pkg::LAD_PSS_LO] = lad_pss;
                next_rdata[vrc_pkg::LAD_NSS_BIT] = lad_nss;
            end
            vrc_pkg::ADDR_LEVEL_SEL: begin
                next_rdata[vrc_pkg::LEVEL_HI:0] = level;
            end
            default: begin
                next_rdata = 8'h00;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            RDATA <= 8'h00;
        end else if (RD) begin
            RDATA <= next_rdata;
        end else begin
            RDATA <= 8'h00;
        end
    end

    // Pin level is asynchronous to the core clock
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
        end else begin
            pin_meta <= PIN_DIGITAL_IN;
            pin_sync <= pin_meta;
        end
    end

    // Registered outputs follow the control state one cycle late
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            FIXED_REF_ENABLE     <= 1'b0;
            FIXED_REF_GAIN       <= vrc_pkg::FIX_GAIN_RESET;
            FIXED_REF_TO_CMP     <= 1'b0;
            FIXED_REF_TO_ADC     <= 1'b0;
            LADDER_ENABLE        <= 1'b0;
            LADDER_CLAMP         <= 1'b1;
            LADDER_LOW_POWER     <= 1'b0;
            LADDER_POS_SEL       <= vrc_pkg::PSS_SUPPLY;
            LADDER_NEG_SEL       <= 1'b0;
            LADDER_LEVEL         <= '0;
            LADDER_PIN_OE        <= 1'b0;
            PIN_DIGITAL_OVERRIDE <= 1'b0;
            PIN_DIGITAL_READ     <= 1'b0;
        end else begin
            FIXED_REF_ENABLE     <= fix_en;
            FIXED_REF_GAIN       <= fix_gain;
            FIXED_REF_TO_CMP     <= fix_en;
            FIXED_REF_TO_ADC     <= fix_en;
            LADDER_ENABLE        <= lad_en;
            LADDER_CLAMP         <= !lad_en;
            LADDER_LOW_POWER     <= lad_lps;
            LADDER_POS_SEL       <= lad_pss;
            LADDER_NEG_SEL       <= lad_nss;
            LADDER_LEVEL         <= level;
            LADDER_PIN_OE        <= lad_oe;
            PIN_DIGITAL_OVERRIDE <= lad_oe;
            PIN_DIGITAL_READ     <= lad_oe ? 1'b0 : pin_sync;
        end
    end

    // Checks
    // The timer drops stable one edge after disable, so one stale cycle is allowed
    stable_needs_en_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        stable |-> fix_en || $past(fix_en))
        else $error("stable set while fixed reference off");
    stable_clear_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        !fix_en |=> !stable) else $error("stable held after disable");
    route_follow_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        FIXED_REF_TO_CMP == FIXED_REF_ENABLE && FIXED_REF_TO_ADC == FIXED_REF_ENABLE)
        else $error("fixed reference routing disagrees with enable");
    pos_sel_follow_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        1'b1 |=> LADDER_POS_SEL == $past(lad_pss))
        else $error("positive source select not forwarded");
    neg_sel_follow_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        1'b1 |=> LADDER_NEG_SEL == $past(lad_nss))
        else $error("negative source select not forwarded");
    level_out_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        1'b1 |=> LADDER_LEVEL == $past(level))
        else $error("level code not forwarded");
    pin_override_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        PIN_DIGITAL_OVERRIDE == LADDER_PIN_OE)
        else $error("pin override disagrees with output enable");
    reset_state_a: assert property (@(posedge CORE_CLK)
        RST |=> level == 5'h00 && !fix_en && !lad_en && !lad_oe && !stable)
        else $error("reset did not clear control state");
    unmapped_write_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        WR && ADDR == 2'h3 |=> $stable(level) && $stable(fix_en) && $stable(lad_en))
        else $error("write to unmapped address changed state");
    stable_read_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        RD && ADDR == vrc_pkg::ADDR_FIXED_CTRL |=> RDATA[6] == $past(stable))
        else $error("stable flag read mismatch");
    fix_write_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        WR && ADDR == vrc_pkg::ADDR_FIXED_CTRL |=> ##1 FIXED_REF_ENABLE == $past(WDATA[7], 2))
        else $error("fixed enable did not follow write");
    reset_clear_a: assert property (@(posedge CORE_CLK)
        RST |=> !FIXED_REF_ENABLE && !LADDER_ENABLE && !LADDER_PIN_OE && LADDER_LEVEL == 5'h00)
        else $error("reset did not clear references");
    unimpl_zero_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        ##1 RDATA[3:0] == 4'h0 || $past(ADDR) != vrc_pkg::ADDR_FIXED_CTRL)
        else $error("unimplemented bits read nonzero");
    level_hi_zero_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        RDATA[7:5] == 3'h0 || $past(ADDR) != vrc_pkg::ADDR_LEVEL_SEL)
        else $error("level register high bits nonzero");
    clamp_inv_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        LADDER_CLAMP != LADDER_ENABLE) else $error("clamp and enable disagree");
    pin_read_zero_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        lad_oe && $past(lad_oe) |=> !PIN_DIGITAL_READ)
        else $error("pin read nonzero while driving reference");
    level_write_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        WR && ADDR == vrc_pkg::ADDR_LEVEL_SEL |=> level == $past(WDATA[4:0]))
        else $error("level code not stored");
    settle_hold_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        $rose(fix_en) |-> !stable[*2]) else $error("stable set at once");

    settle_c: cover property (@(posedge CORE_CLK) disable iff (RST) $rose(stable));
    pin_c: cover property (@(posedge CORE_CLK) disable iff (RST) $rose(LADDER_PIN_OE));
    level_c: cover property (@(posedge CORE_CLK) disable iff (RST) LADDER_LEVEL == 5'h1f);
    fixed_src_c: cover property (@(posedge CORE_CLK) disable iff (RST)
        LADDER_POS_SEL == vrc_pkg::PSS_FIXED);
endmodule
